// file: rtl/lmx_top.sv
// Lane router, sync window monitor and pin function register bank.
// Functional notes
// [R1] Each routing register holds an odd-lane selector in bits 7-4 and an even-lane selector in bits 3-0.
// [R2] Selector value n routes internal bus lane n, 0000 to lane zero and 1111 to lane fifteen.
// [R3] Software sets the router enable bit at bit 7 of 0x116 before routing selectors take effect.
// [R4] With the router enable clear the selectors are ignored, when set they govern every output lane.
// [R5] With routing disabled each output lane carries the internal lane of the same index.
// [R6] Software sets the high input frequency bit above 500MHz, clears it below, and writes zeros elsewhere.
// [R7] The sync detect bit sets on a detected reference and holds until its clear bit or a reset.
// [R8] The combined window flag is the OR of the five window flags.
// [R9] The sync reference is captured on the falling clock edge as the window reference.
// [R10] A transition within -60 to +140 ps raises the matching flag, all flags refresh on each rising edge.
// [R11] Flag bins cover leads of 20-60ps, within 20ps, and lags of 20-60, 60-100 and 100-140ps.
// [R12] The five-bit pin code gives pin 0 the sync input for 00000 and 01000, plus power down or reference select on pin 1 for 00011 and 00100.
// [R13] Code 00101 makes both pins oscillator profile select inputs, pin 0 low bit and pin 1 high bit.
// [R14] Code 10010 drives overrange of channel A on pin 0 and of channel B on pin 1.
// [R15] Code 01010 makes pin 0 power down, and 01011 adds the combined overrange on pin 1.
// [R16] Code 01001 makes pin 0 the sync input and drives the combined overrange on pin 1.
// [R17] Pins without a function are ignored as inputs and do not drive.
`timescale 1ns/1ps
`default_nettype none
module lmx_top
   import lmx_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic                 nrst_in,
   input  wire logic                 ce_in,
   input  wire logic [ADDR_W-1:0]    reg_addr_in,
   input  wire logic [DATA_W-1:0]    reg_wdata_in,
   input  wire logic                 reg_wr_in,
   input  wire logic                 reg_rd_in,
   output logic      [DATA_W-1:0]    reg_rdata_out,
   input  wire logic [NUM_LANES-1:0] internal_bus_lane_in,
   output logic      [NUM_LANES-1:0] output_lane_out,
   output logic                      high_input_freq_mode_out,
   input  wire logic [WIN_FLAGS-1:0] window_hit_in,
   input  wire logic                 overrange_a_in,
   input  wire logic                 overrange_b_in,
   input  wire logic [1:0]           gp_pin_in,
   output logic      [1:0]           gp_pin_out,
   output logic      [1:0]           gp_pin_oe_out,
   output logic                      power_down_out,
   output logic                      ext_ref_sel_out,
   output logic      [1:0]           osc_profile_sel_out,
   output logic                      irq_out
);
   logic [DATA_W-1:0]    out_ctrl_reg;
   logic [DATA_W-1:0]    route_reg [NUM_PAIRS];
   logic [DATA_W-1:0]    high_freq_reg;
   logic [PIN_W-1:0]     pin_code_reg;
   logic [IRQ_W-1:0]     irq_stat_reg;
   logic [IRQ_W-1:0]     irq_en_reg;
   logic [IRQ_W-1:0]     irq_clr;
   logic [IRQ_W-1:0]     irq_evt;
   logic [IRQ_W-1:0]     irq_stat_next;
   logic [DATA_W-1:0]    rdata_next;
   logic [NUM_LANES-1:0] routed;
   logic [PAIR_W-1:0]    pair_idx;
   logic                 in_route_range;
   logic                 route_en;
   logic                 seen_clr;
   logic                 seen;
   logic                 any_flag;
   logic [WIN_FLAGS-1:0] bin_flags;
   logic                 seen_set;
   logic                 window_evt;
   logic                 pin0_is_sync;
   logic                 sync_ref_src;
   logic [1:0]           pin_out_next;
   logic [1:0]           pin_oe_next;
   logic                 pdn_next;
   logic                 ext_ref_next;
   logic [1:0]           osc_sel_next;
   logic                 ovr_combined;

   // Register writes.

   assign in_route_range = (reg_addr_in >= OFS_ROUTE_FIRST) &&
                           (reg_addr_in <= OFS_ROUTE_LAST);
   assign pair_idx = PAIR_W'(reg_addr_in - OFS_ROUTE_FIRST);

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         out_ctrl_reg <= RST_BYTE;
      end else if (ce_in && reg_wr_in && reg_addr_in == OFS_OUT_CTRL) begin
         out_ctrl_reg <= reg_wdata_in; // [R3]
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < NUM_PAIRS; i++) begin
            route_reg[i] <= RST_BYTE;
         end
      end else if (ce_in && reg_wr_in && in_route_range) begin
         route_reg[pair_idx] <= reg_wdata_in; // [R1]
      end
   end

   // Only the mode bit is kept, so stray writes to the zero bits vanish.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         high_freq_reg <= RST_BYTE;
      end else if (ce_in && reg_wr_in && reg_addr_in == OFS_HIGH_FREQ) begin
         high_freq_reg <= RST_BYTE;
         high_freq_reg[BIT_HIGH_FREQ] <= reg_wdata_in[BIT_HIGH_FREQ]; // [R6]
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_code_reg <= RST_PIN_CODE;
      end else if (ce_in && reg_wr_in && reg_addr_in == OFS_PIN_FUNC) begin
         pin_code_reg <= reg_wdata_in[PIN_W-1:0]; // [R12]
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_en_reg <= RST_IRQ;
      end else if (ce_in && reg_wr_in && reg_addr_in == OFS_IRQ_EN) begin
         irq_en_reg <= reg_wdata_in[IRQ_W-1:0];
      end
   end

   // The detect clear is a self-clearing pulse and never reads back.
   assign seen_clr = reg_wr_in && (reg_addr_in == OFS_SYNC_CLR) &&
                     reg_wdata_in[BIT_SYNC_CLR];

   // Interrupt status: a new event beats a clear in the same cycle.

   assign irq_clr = (reg_wr_in && reg_addr_in == OFS_IRQ_CLR) ?
                    reg_wdata_in[IRQ_W-1:0] : RST_IRQ;

   always_comb begin
      irq_evt = RST_IRQ;
      irq_evt[IRQ_SEEN]   = seen_set;
      irq_evt[IRQ_WINDOW] = window_evt;
      irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_stat_reg <= RST_IRQ;
      end else if (ce_in) begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_out <= 1'b0;
      end else if (ce_in) begin
         irq_out <= |(irq_stat_next & irq_en_reg);
      end
   end

   // Register reads: data stand in the cycle after the strobe only.

   always_comb begin
      rdata_next = RST_BYTE;
      if (in_route_range) begin
         rdata_next = route_reg[pair_idx];
      end else begin
         unique case (reg_addr_in)
            OFS_OUT_CTRL:  rdata_next = out_ctrl_reg;
            OFS_HIGH_FREQ: rdata_next = high_freq_reg;
            OFS_SYNC_STAT: begin
               rdata_next[BIT_SEEN] = seen; // [R7]
               rdata_next[BIT_ANY]  = any_flag; // [R8]
               rdata_next[WIN_FLAGS-1:0] = bin_flags; // [R11]
            end
            OFS_PIN_FUNC:  rdata_next[PIN_W-1:0] = pin_code_reg;
            OFS_IRQ_STAT:  rdata_next[IRQ_W-1:0] = irq_stat_reg;
            OFS_IRQ_EN:    rdata_next[IRQ_W-1:0] = irq_en_reg;
            default:       rdata_next = RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= RST_BYTE;
      end else if (ce_in) begin
         reg_rdata_out <= reg_rd_in ? rdata_next : RST_BYTE;
      end
   end

   // Lane router.

   assign route_en = out_ctrl_reg[BIT_ROUTE_EN]; // [R3] [R4]

   for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      logic [SEL_W-1:0] sel;
      if (l % 2 == 1) begin : g_odd
         assign sel = route_reg[l/2][ODD_SEL_LSB +: SEL_W]; // [R1]
      end else begin : g_even
         assign sel = route_reg[l/2][EVEN_SEL_LSB +: SEL_W]; // [R1]
      end
      lmx_lane_sel #(
         .LANE(l)
      ) u_sel (
         .bus_in      (internal_bus_lane_in),
         .sel_in      (sel),
         .route_en_in (route_en),
         .lane_out    (routed[l])
      );
   end

   // One cycle of latency buys clean flop-driven lane outputs.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         output_lane_out <= '0;
         high_input_freq_mode_out <= 1'b0;
      end else if (ce_in) begin
         output_lane_out <= routed; // [R2] [R4] [R5]
         high_input_freq_mode_out <= high_freq_reg[BIT_HIGH_FREQ];
      end
   end

   // Sync reference monitor.

   always_comb begin
      unique case (pin_code_reg)
         PF_SYNC_ONLY, PF_SYNC_ONLY_ALT, PF_SYNC_PDN,
         PF_SYNC_EXTREF, PF_SYNC_OVR: pin0_is_sync = 1'b1; // [R12] [R16]
         default: pin0_is_sync = 1'b0; // [R17]
      endcase
   end

   assign sync_ref_src = pin0_is_sync & gp_pin_in[0];

   lmx_sync_mon u_mon (
      .clk_sys_in     (clk_sys_in),
      .nrst_in        (nrst_in),
      .ce_in          (ce_in),
      .sync_ref_in    (sync_ref_src),
      .window_hit_in  (window_hit_in),
      .seen_clr_in    (seen_clr),
      .seen_out       (seen),
      .any_flag_out   (any_flag),
      .bin_flags_out  (bin_flags),
      .seen_set_out   (seen_set),
      .window_evt_out (window_evt)
   );

   // Pin function decode; unused pins float and their inputs are masked.

   assign ovr_combined = overrange_a_in | overrange_b_in;

   always_comb begin
      pin_out_next = 2'h0;
      pin_oe_next  = 2'h0;
      pdn_next     = 1'b0;
      ext_ref_next = 1'b0;
      osc_sel_next = 2'h0;
      unique case (pin_code_reg)
         PF_SYNC_PDN: begin
            pdn_next = gp_pin_in[1]; // [R12]
         end
         PF_SYNC_EXTREF: begin
            ext_ref_next = gp_pin_in[1]; // [R12]
         end
         PF_OSC_SEL: begin
            osc_sel_next = {gp_pin_in[1], gp_pin_in[0]}; // [R13]
         end
         PF_SYNC_OVR: begin
            pin_out_next[1] = ovr_combined; // [R16]
            pin_oe_next[1]  = 1'b1; // [R16]
         end
         PF_PDN_ONLY: begin
            pdn_next = gp_pin_in[0]; // [R15]
         end
         PF_PDN_OVR: begin
            pdn_next = gp_pin_in[0]; // [R15]
            pin_out_next[1] = ovr_combined; // [R15]
            pin_oe_next[1]  = 1'b1; // [R15]
         end
         PF_OVR_SPLIT: begin
            pin_out_next = {overrange_b_in, overrange_a_in}; // [R14]
            pin_oe_next  = 2'h3; // [R14]
         end
         default: begin
            pin_oe_next = 2'h0; // [R17]
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gp_pin_out          <= 2'h0;
         gp_pin_oe_out       <= 2'h0;
         power_down_out      <= 1'b0;
         ext_ref_sel_out     <= 1'b0;
         osc_profile_sel_out <= 2'h0;
      end else if (ce_in) begin
         gp_pin_out          <= pin_out_next;
         gp_pin_oe_out       <= pin_oe_next; // [R17]
         power_down_out      <= pdn_next;
         ext_ref_sel_out     <= ext_ref_next;
         osc_profile_sel_out <= osc_sel_next;
      end
   end
endmodule : lmx_top
`default_nettype wire

// file: rtl/lmx_pkg.sv
// Constants shared by the lane router, sync monitor and pin function logic.
package lmx_pkg;
   localparam int ADDR_W    = 12;
   localparam int DATA_W    = 8;
   localparam int NUM_LANES = 16;
   localparam int SEL_W     = 4;
   localparam int NUM_PAIRS = 8;
   localparam int PAIR_W    = 3;
   localparam int WIN_FLAGS = 5;
   localparam int PIN_W     = 5;
   localparam int IRQ_W     = 2;

   localparam logic [ADDR_W-1:0] OFS_SYNC_CLR    = 12'h102;
   localparam logic [ADDR_W-1:0] OFS_OUT_CTRL    = 12'h116;
   localparam logic [ADDR_W-1:0] OFS_ROUTE_FIRST = 12'h117;
   localparam logic [ADDR_W-1:0] OFS_ROUTE_LAST  = 12'h11e;
   localparam logic [ADDR_W-1:0] OFS_HIGH_FREQ   = 12'h132;
   localparam logic [ADDR_W-1:0] OFS_SYNC_STAT   = 12'h140;
   localparam logic [ADDR_W-1:0] OFS_PIN_FUNC    = 12'h146;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT    = 12'h150;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN      = 12'h151;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR     = 12'h152;

   localparam int BIT_ROUTE_EN  = 7;
   localparam int BIT_SYNC_CLR  = 6;
   localparam int BIT_HIGH_FREQ = 7;
   localparam int BIT_SEEN      = 6;
   localparam int BIT_ANY       = 5;
   localparam int ODD_SEL_LSB   = 4;
   localparam int EVEN_SEL_LSB  = 0;
   localparam int IRQ_SEEN      = 0;
   localparam int IRQ_WINDOW    = 1;

   localparam logic [DATA_W-1:0] RST_BYTE     = 8'h00;
   localparam logic [PIN_W-1:0]  RST_PIN_CODE = 5'h00;
   localparam logic [IRQ_W-1:0]  RST_IRQ      = 2'h0;

   localparam logic [PIN_W-1:0] PF_SYNC_ONLY     = 5'h00;
   localparam logic [PIN_W-1:0] PF_SYNC_PDN      = 5'h03;
   localparam logic [PIN_W-1:0] PF_SYNC_EXTREF   = 5'h04;
   localparam logic [PIN_W-1:0] PF_OSC_SEL       = 5'h05;
   localparam logic [PIN_W-1:0] PF_SYNC_ONLY_ALT = 5'h08;
   localparam logic [PIN_W-1:0] PF_SYNC_OVR      = 5'h09;
   localparam logic [PIN_W-1:0] PF_PDN_ONLY      = 5'h0a;
   localparam logic [PIN_W-1:0] PF_PDN_OVR       = 5'h0b;
   localparam logic [PIN_W-1:0] PF_OVR_SPLIT     = 5'h12;
endpackage : lmx_pkg

// file: rtl/lmx_lane_sel.sv
// One output lane selector of the lane router.
`timescale 1ns/1ps
`default_nettype none
module lmx_lane_sel
   import lmx_pkg::*;
#(
   parameter int LANE = 0
) (
   input  wire logic [NUM_LANES-1:0] bus_in,
   input  wire logic [SEL_W-1:0]     sel_in,
   input  wire logic                 route_en_in,
   output logic                      lane_out
);
   localparam logic [SEL_W-1:0] OWN_IDX = SEL_W'(LANE);

   always_comb begin
      if (route_en_in) begin
         lane_out = bus_in[sel_in]; // [R2] [R4]
      end else begin
         lane_out = bus_in[OWN_IDX]; // [R4] [R5]
      end
   end
endmodule : lmx_lane_sel
`default_nettype wire

// file: rtl/lmx_sync_mon.sv
// Sync reference capture, detect flag and timing window flags.
`timescale 1ns/1ps
`default_nettype none
module lmx_sync_mon
   import lmx_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic                 nrst_in,
   input  wire logic                 ce_in,
   input  wire logic                 sync_ref_in,
   input  wire logic [WIN_FLAGS-1:0] window_hit_in,
   input  wire logic                 seen_clr_in,
   output logic                      seen_out,
   output logic                      any_flag_out,
   output logic [WIN_FLAGS-1:0]      bin_flags_out,
   output logic                      seen_set_out,
   output logic                      window_evt_out
);
   logic cap_reg;
   logic cap_d_reg;
   logic rise;

   // The falling edge gives the reference half a cycle of setup margin.
   always_ff @(negedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cap_reg <= 1'b0;
      end else if (ce_in) begin
         cap_reg <= sync_ref_in; // [R9]
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cap_d_reg <= 1'b0;
      end else if (ce_in) begin
         cap_d_reg <= cap_reg;
      end
   end

   assign rise = cap_reg & ~cap_d_reg;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bin_flags_out <= '0;
         any_flag_out  <= 1'b0;
      end else if (ce_in && rise) begin
         bin_flags_out <= window_hit_in; // [R10] [R11]
         any_flag_out  <= |window_hit_in; // [R8]
      end
   end

   // A detection in the clear cycle wins so no edge is lost.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         seen_out <= 1'b0;
      end else if (ce_in) begin
         if (rise) begin
            seen_out <= 1'b1; // [R7]
         end else if (seen_clr_in) begin
            seen_out <= 1'b0; // [R7]
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         seen_set_out   <= 1'b0;
         window_evt_out <= 1'b0;
      end else if (ce_in) begin
         seen_set_out   <= rise;
         window_evt_out <= rise & (|window_hit_in);
      end
   end
endmodule : lmx_sync_mon
`default_nettype wire

// file: tb/lmx_top_properties.sv
// Port checks for the lane router, the combined window flag and the pin function block.
`timescale 1ns/1ps
`default_nettype none
module lmx_top_properties
   import lmx_pkg::*;
(
   input wire logic                 clk_sys_in,
   input wire logic                 nrst_in,
   input wire logic                 ce_in,
   input wire logic [ADDR_W-1:0]    reg_addr_in,
   input wire logic [DATA_W-1:0]    reg_wdata_in,
   input wire logic                 reg_wr_in,
   input wire logic                 reg_rd_in,
   input wire logic [DATA_W-1:0]    reg_rdata_out,
   input wire logic [NUM_LANES-1:0] internal_bus_lane_in,
   input wire logic [NUM_LANES-1:0] output_lane_out,
   input wire logic                 overrange_a_in,
   input wire logic                 overrange_b_in,
   input wire logic [1:0]           gp_pin_in,
   input wire logic [1:0]           gp_pin_out,
   input wire logic [1:0]           gp_pin_oe_out,
   input wire logic                 power_down_out,
   input wire logic                 ext_ref_sel_out,
   input wire logic [1:0]           osc_profile_sel_out
);
   logic                 en_q;
   logic [PIN_W-1:0]     code_q;
   logic [SEL_W-1:0]     sel_q [NUM_LANES];
   logic [PAIR_W-1:0]    pair;
   logic [NUM_LANES-1:0] lane_exp;
   logic [1:0]           oe_exp;
   logic                 pdn_exp;
   logic                 ext_exp;
   logic                 ovr_any;

   assign pair = PAIR_W'(reg_addr_in - OFS_ROUTE_FIRST);
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         en_q   <= 1'b0;
         code_q <= RST_PIN_CODE;
         sel_q  <= '{default: '0};
      end else if (ce_in && reg_wr_in) begin
         if (reg_addr_in == OFS_OUT_CTRL) begin
            en_q <= reg_wdata_in[BIT_ROUTE_EN];
         end
         if (reg_addr_in == OFS_PIN_FUNC) begin
            code_q <= reg_wdata_in[PIN_W-1:0];
         end
         if (reg_addr_in >= OFS_ROUTE_FIRST &&
             reg_addr_in <= OFS_ROUTE_LAST) begin
            sel_q[{pair, 1'b0}] <= reg_wdata_in[3:0];
            sel_q[{pair, 1'b1}] <= reg_wdata_in[7:4];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NUM_LANES; i++) begin
         lane_exp[i] = en_q ? internal_bus_lane_in[sel_q[i]]
                            : internal_bus_lane_in[i];
      end
      oe_exp  = (code_q == PF_OVR_SPLIT) ? 2'b11 :
                (code_q == PF_SYNC_OVR || code_q == PF_PDN_OVR) ? 2'b10
                : 2'b00;
      pdn_exp = (code_q == PF_SYNC_PDN) ? gp_pin_in[1] :
                (code_q == PF_PDN_ONLY || code_q == PF_PDN_OVR) ?
                gp_pin_in[0] : 1'b0;
      ext_exp = (code_q == PF_SYNC_EXTREF) && gp_pin_in[1];
      ovr_any = overrange_a_in || overrange_b_in;
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   a_lane_route: assert property (
      ce_in |=> output_lane_out == $past(lane_exp))
      else $error("output lanes differ from the routing selection");
   a_any_flag_or: assert property (
      ce_in && reg_rd_in && reg_addr_in == OFS_SYNC_STAT |=>
      reg_rdata_out[BIT_ANY] == |reg_rdata_out[WIN_FLAGS-1:0])
      else $error("combined window flag is not the OR of the bins");
   a_split_ovr: assert property (
      ce_in && code_q == PF_OVR_SPLIT |=>
      gp_pin_out == {$past(overrange_b_in), $past(overrange_a_in)})
      else $error("split overrange pins carry wrong levels");
   a_comb_ovr: assert property (
      ce_in && (code_q == PF_SYNC_OVR || code_q == PF_PDN_OVR) |=>
      gp_pin_out[1] == $past(ovr_any))
      else $error("combined overrange pin carries a wrong level");
   a_pin_drive_en: assert property (
      ce_in |=> gp_pin_oe_out == $past(oe_exp))
      else $error("pin drive enables do not match the pin code");
   a_osc_select: assert property (
      ce_in && code_q == PF_OSC_SEL |=>
      osc_profile_sel_out == $past(gp_pin_in))
      else $error("oscillator profile select does not follow the pins");
   a_power_down: assert property (
      ce_in |=> power_down_out == $past(pdn_exp))
      else $error("power down request does not follow its pin");
   a_ext_ref_sel: assert property (
      ce_in |=> ext_ref_sel_out == $past(ext_exp))
      else $error("reference select does not follow pin 1");
endmodule : lmx_top_properties

bind lmx_top lmx_top_properties u_props (.clk_sys_in, .nrst_in, .ce_in,
   .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
   .internal_bus_lane_in, .output_lane_out, .overrange_a_in,
   .overrange_b_in, .gp_pin_in, .gp_pin_out, .gp_pin_oe_out,
   .power_down_out, .ext_ref_sel_out, .osc_profile_sel_out);
`default_nettype wire

// file: tb/lmx_lane_rx.sv
// Receiver model that captures the routed output lanes every clock.
`timescale 1ns/1ps
`default_nettype none
module lmx_lane_rx
   import lmx_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic                 nrst_in,
   input  wire logic [NUM_LANES-1:0] lane_in,
   output logic      [NUM_LANES-1:0] word_out
);
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         word_out <= '0;
      end else begin
         word_out <= lane_in;
      end
   end
endmodule : lmx_lane_rx
`default_nettype wire

// file: tb/lmx_top_test.sv
// Self-checking bench for the lane router, sync monitor and pin block.
`timescale 1ns/1ps
`default_nettype none
module lmx_top_test
   import lmx_pkg::*;
();
   logic                 clk_sys_in = 1'b0;
   logic                 nrst_in = 1'b1;
   logic                 ce_in = 1'b1;
   logic [ADDR_W-1:0]    addr = '0;
   logic [DATA_W-1:0]    wdata = '0;
   logic                 wr_s = 1'b0;
   logic                 rd_s = 1'b0;
   logic [NUM_LANES-1:0] lanes = '0;
   logic [WIN_FLAGS-1:0] hits = '0;
   logic [1:0]           ovr = '0;
   logic [1:0]           pin_drv = '0;
   logic [1:0]           pin_out, pin_oe, osc;
   wire logic [1:0]      pin_wire;
   logic [DATA_W-1:0]    rdata;
   logic [NUM_LANES-1:0] lane_q, rx_word;
   logic                 hf, pdn, ext, irq;
   logic [SEL_W-1:0]     sel [NUM_LANES];
   int                   err_total = 0, n_checks = 0, cyc = 0;

   // A pin the block drives shows its value, otherwise the bench's level.
   assign pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_drv);
   always #25 clk_sys_in = ~clk_sys_in;

   lmx_top DUT (.clk_sys_in, .nrst_in, .ce_in, .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
      .reg_rdata_out(rdata), .internal_bus_lane_in(lanes),
      .output_lane_out(lane_q), .high_input_freq_mode_out(hf),
      .window_hit_in(hits), .overrange_a_in(ovr[0]),
      .overrange_b_in(ovr[1]), .gp_pin_in(pin_wire),
      .gp_pin_out(pin_out), .gp_pin_oe_out(pin_oe),
      .power_down_out(pdn), .ext_ref_sel_out(ext),
      .osc_profile_sel_out(osc), .irq_out(irq));
   lmx_lane_rx u_rx (.clk_sys_in, .nrst_in, .lane_in(lane_q),
      .word_out(rx_word));

   task automatic finish_test();
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk_sys_in);
      wr_s  <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      @(posedge clk_sys_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys_in);
      rd_s <= 1'b0;
      #1 chk(rdata, e);
   endtask : rchk

   function automatic logic [15:0] route_exp(input logic [15:0] v,
                                             input logic en);
      for (int i = 0; i < NUM_LANES; i++) begin
         route_exp[i] = en ? v[sel[i]] : v[i];
      end
   endfunction : route_exp

   function automatic logic [7:0] pin_exp(input logic [4:0] c,
      input logic [1:0] p, input logic [1:0] o);
      logic [1:0] oe, q, os;
      logic pd, ex;
      {oe, q, pd, ex, os} = '0;
      case (c)
         5'h03: pd = p[1];
         5'h04: ex = p[1];
         5'h05: os = p;
         5'h09, 5'h0b: begin
            oe = 2'b10;
            q  = {|o, 1'b0};
            pd = (c == 5'h0b) && p[0];
         end
         5'h0a: pd = p[0];
         5'h12: {oe, q} = {2'b11, o[1], o[0]};
         default: ;
      endcase
      return {oe, q, pd, ex, os};
   endfunction : pin_exp

   task automatic lane_run(input logic en);
      logic [NUM_LANES-1:0] v;
      for (int j = 0; j < 6; j++) begin
         v = (j == 0) ? 16'h8001 : 16'($urandom);
         @(posedge clk_sys_in);
         lanes <= v;
         repeat (2) @(posedge clk_sys_in);
         #1 chk(rx_word, route_exp(v, en));
      end
   endtask : lane_run

   task automatic sync_pulse(input logic [WIN_FLAGS-1:0] h);
      @(posedge clk_sys_in);
      hits       <= h;
      pin_drv[0] <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      pin_drv[0] <= 1'b0;
      hits       <= ~h;
      repeat (2) @(posedge clk_sys_in);
   endtask : sync_pulse

   initial begin : main
      logic [7:0] b;
      logic [4:0] codes [11];
      logic [4:0] hv [3];
      logic [ADDR_W-1:0] zr [9];
      codes = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0a, 5'h0b,
                5'h12, 5'h1f, 5'h01};
      hv = '{5'h01, 5'h10, 5'h00};
      zr = '{12'h117, 12'h11e, 12'h132, 12'h140, 12'h146, 12'h150,
             12'h151, 12'h100, 12'h152};
      nrst_in <= 1'b0;
      void'($urandom(79460));
      repeat (20) @(posedge clk_sys_in);
      chk({hf, irq, pin_oe, rdata}, '0);
      nrst_in <= 1'b1;
      foreach (zr[k]) rchk(zr[k], 8'h00);
      for (int k = 0; k < NUM_PAIRS; k++) begin
         b = (k == 0) ? 8'hf0 : 8'($urandom);
         wr(OFS_ROUTE_FIRST + 12'(k), b);
         {sel[2*k+1], sel[2*k]} = b;
         rchk(OFS_ROUTE_FIRST + 12'(k), b);
      end
      lane_run(1'b0);
      wr(OFS_OUT_CTRL, 8'h80);
      lane_run(1'b1);
      wr(OFS_OUT_CTRL, 8'h00);
      lane_run(1'b0);
      wr(OFS_HIGH_FREQ, 8'h80);
      rchk(OFS_HIGH_FREQ, 8'h80);
      chk(hf, 1'b1);
      wr(OFS_HIGH_FREQ, 8'h00);
      rchk(OFS_HIGH_FREQ, 8'h00);
      chk(hf, 1'b0);
      @(posedge clk_sys_in);
      ce_in <= 1'b0;
      wr(OFS_HIGH_FREQ, 8'h80);
      ce_in <= 1'b1;
      rchk(OFS_HIGH_FREQ, 8'h00);
      wr(12'h100, 8'hff);
      rchk(12'h100, 8'h00);
      foreach (codes[k]) begin
         wr(OFS_PIN_FUNC, {3'b000, codes[k]});
         rchk(OFS_PIN_FUNC, {3'b000, codes[k]});
         repeat (4) begin
            @(posedge clk_sys_in);
            pin_drv <= 2'($urandom);
            ovr     <= 2'($urandom);
            @(posedge clk_sys_in);
            #1 chk({pin_oe, pin_out & pin_oe, pdn, ext, osc},
                   pin_exp(codes[k], pin_drv, ovr));
         end
      end
      @(posedge clk_sys_in);
      pin_drv <= 2'b00;
      wr(OFS_PIN_FUNC, 8'h00);
      wr(OFS_SYNC_CLR, 8'h40);
      wr(OFS_IRQ_CLR, 8'h03);
      wr(OFS_IRQ_EN, 8'h03);
      wr(OFS_SYNC_STAT, 8'hff);
      rchk(OFS_SYNC_STAT, 8'h00);
      foreach (hv[n]) begin
         sync_pulse(hv[n]);
         rchk(OFS_SYNC_STAT, {2'b01, |hv[n], hv[n]});
         chk(irq, 1'b1);
      end
      rchk(OFS_IRQ_STAT, 8'h03);
      wr(OFS_IRQ_EN, 8'h00);
      rchk(OFS_IRQ_EN, 8'h00);
      chk(irq, 1'b0);
      wr(OFS_IRQ_CLR, 8'h03);
      wr(OFS_IRQ_EN, 8'h03);
      rchk(OFS_IRQ_STAT, 8'h00);
      chk(irq, 1'b0);
      wr(OFS_SYNC_CLR, 8'h40);
      rchk(OFS_SYNC_STAT, 8'h00);
      wr(OFS_PIN_FUNC, 8'h05);
      sync_pulse(5'h1f);
      rchk(OFS_SYNC_STAT, 8'h00);
      finish_test();
   end
endmodule : lmx_top_test
`default_nettype wire
